// File: src/asq_sequencer.sv
// scan sequencer top: command decode, mode registers, scan control, result fifo
`timescale 1ns/1ps
module asq_sequencer (
    // clock and reset
    input wire logic CLK,
    input wire logic RSTN,
    // serial link pins
    input wire logic SCLK,
    input wire logic CSN,
    input wire logic DIN,
    output logic DOUT,
    // conversion control pins
    input wire logic CNVSTN,
    output logic EOCN,
    // converter core
    output logic [asq_pkg::CH_W-1:0] MUX_CH,
    output logic CONV_START,
    input wire logic CONV_DONE,
    input wire logic [asq_pkg::RES_W-1:0] CONV_DATA,
    // analog setup
    output logic [asq_pkg::CFG_W-1:0] PAIR_UNI,
    output logic [asq_pkg::CFG_W-1:0] PAIR_BIP,
    output logic [asq_pkg::CFG_W-1:0] SPAN_SEL,
    output logic [1:0] POWER_MODE
);
    import asq_pkg::*;

    logic frame_start, frame_end, word_valid, mux_step, cs_idle;
    logic [WORD_W-1:0] rx_word, tx_word;
    logic cnv_s1, cnv_s2, cnv_d;
    logic [3:0] scan_mode, chsel;
    logic chan_id, software_convert_flag, echo_pend;
    logic [CFG_W-1:0] cfg, list0, list1;
    logic [WORD_W-1:0] echo_word;
    logic [SEQ_W-1:0] seq_last, load_idx, seq_idx;
    logic loading;
    logic [CH_W-1:0] seq_mem [SEQ_DEPTH];
    asq_state_t state;
    logic [ACC_W-1:0] acc;
    logic [5:0] avg_cnt;
    logic [3:0] rep_cnt;
    logic [RES_W-1:0] ext_res;
    logic [CH_W-1:0] ext_ch;
    logic [WORD_W-1:0] fifo_mem [FIFO_DEPTH];
    logic [PTR_W-1:0] wr_ptr, rd_ptr;
    logic [PTR_W:0] fifo_cnt;

    asq_frame u_frame (
        .clk(CLK),
        .rst_n(RSTN),
        .sclk(SCLK),
        .csn(CSN),
        .din(DIN),
        .dout(DOUT),
        .tx_word(tx_word),
        .frame_start(frame_start),
        .frame_end(frame_end),
        .word_valid(word_valid),
        .rx_word(rx_word),
        .mux_step(mux_step),
        .cs_idle(cs_idle)
    );

    // membership of a channel in the active scan set, lowest member at or above start
    function automatic logic [4:0] find_ch(input logic [4:0] start, input logic [3:0] mode,
                                           input logic [3:0] sel, input logic [15:0] list);
        logic [4:0] r;
        logic hit;
        r = 5'h10;
        for (int i = 15; i >= 0; i--) begin
            case (mode)
                SCAN_STD_INT, SCAN_STD_EXT: hit = (4'(i) <= sel);
                SCAN_UP_INT, SCAN_UP_EXT: hit = (4'(i) >= sel) && (4'(i) <= CH_TOP);
                SCAN_LIST_INT, SCAN_LIST_EXT: hit = list[i];
                default: hit = (4'(i) == sel);
            endcase
            if (hit && 5'(i) >= start) begin
                r = 5'(i);
            end
        end
        return r;
    endfunction : find_ch

    // command decode
    wire [3:0] code = rx_word[14:CODE_LO];
    wire is_mode = word_valid & ~loading & ~rx_word[SEL_BIT];
    wire is_reg = word_valid & ~loading & rx_word[SEL_BIT];
    wire new_null = (code == SCAN_NULL);
    wire [1:0] rst_field = rx_word[6:RSTF_LO];
    wire rst_all = is_mode & (rst_field == RSTF_ALL);
    wire fifo_clr = (is_mode & (rst_field == RSTF_FIFO)) | rst_all;
    wire wr_cfg = is_reg & (code == REG_CFG);
    wire wr_seq = is_reg & (code == REG_SEQ);
    wire int_mode = (scan_mode == SCAN_REPEAT) | (scan_mode == SCAN_STD_INT) |
                    (scan_mode == SCAN_UP_INT) | (scan_mode == SCAN_LIST_INT);
    wire ext_auto = (scan_mode == SCAN_STD_EXT) | (scan_mode == SCAN_UP_EXT) |
                    (scan_mode == SCAN_LIST_EXT);
    wire [15:0] chan_list = {list0[10:LIST_LO], list1[10:LIST_LO]};
    wire [4:0] next_hit = find_ch({1'b0, MUX_CH} + 5'h01, scan_mode, chsel, chan_list);
    wire [4:0] first_hit = find_ch(5'h00, scan_mode, chsel, chan_list);
    wire [SEQ_W-1:0] seq_next = (seq_idx == seq_last) ? 8'h00 : seq_idx + 8'h01;
    wire cnv_rise = cnv_s2 & ~cnv_d;
    wire cnv_fall = ~cnv_s2 & cnv_d;
    wire trig = (state == ST_IDLE) & int_mode & ((cnv_rise & cs_idle) | (frame_end & software_convert_flag));
    // averaging and repeat counts
    wire avg_on = cfg[AVG_ON_BIT];
    wire [1:0] navg = cfg[8:NAVG_LO];
    wire [5:0] avg_last = 6'((6'h04 << navg) - 6'h01);
    wire [3:0] rep_last = {cfg[6:NSCAN_LO], 2'h3};
    wire [ACC_W-1:0] acc_sum = acc + ACC_W'(CONV_DATA);
    // shift amount widened so that 32 samples divide by 32, not wrap to 2
    wire [RES_W-1:0] avg_val = avg_on ? RES_W'(acc_sum >> (3'(navg) + 3'h2)) : CONV_DATA;
    wire conv_last = ~avg_on | (avg_cnt == avg_last);
    wire push = (state == ST_WAIT) & CONV_DONE & conv_last;
    wire rep_more = (scan_mode == SCAN_REPEAT) & (rep_cnt != rep_last);
    wire scan_done = push & ~rep_more & next_hit[4];
    wire pop = frame_start & int_mode & ~echo_pend & (fifo_cnt != 5'h00);
    wire [WORD_W-1:0] fifo_head = (fifo_cnt != 5'h00) ? fifo_mem[rd_ptr] : 16'h0000;
    wire [WORD_W-1:0] ext_word = chan_id ? {ext_ch, ext_res} : {1'b0, ext_res, 3'h0};
    assign tx_word = echo_pend ? echo_word : (int_mode ? fifo_head : ext_word);

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            {cnv_s1, cnv_s2, cnv_d} <= 3'h7;
        end else begin
            {cnv_s1, cnv_s2, cnv_d} <= {CNVSTN, cnv_s1, cnv_s2};
        end
    end

    // register file
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            scan_mode <= SCAN_RST;
            chsel <= CHSEL_RST;
            POWER_MODE <= PM_RST;
            {chan_id, software_convert_flag, echo_pend, loading} <= 4'h0;
            {cfg, PAIR_UNI, PAIR_BIP, SPAN_SEL, list0, list1} <= {6{CFG_RST}};
            echo_word <= 16'h0000;
            {seq_last, load_idx} <= 16'h0000;
        end else begin
            if (scan_done) begin
                software_convert_flag <= 1'b0;
            end
            if (frame_start) begin
                echo_pend <= 1'b0;
            end
            if (rst_all) begin
                scan_mode <= SCAN_RST;
                chsel <= CHSEL_RST;
                POWER_MODE <= PM_RST;
                {chan_id, software_convert_flag, echo_pend} <= 3'h0;
                {cfg, PAIR_UNI, PAIR_BIP, SPAN_SEL, list0, list1} <= {6{CFG_RST}};
            end else if (is_mode) begin
                if (!new_null) begin
                    scan_mode <= code;
                    chsel <= rx_word[10:CHSEL_LO];
                    chan_id <= rx_word[CHANID_BIT];
                end
                POWER_MODE <= rx_word[4:PM_LO];
                if (rx_word[SOFTWARE_CONVERT_FLAG_BIT]) begin
                    software_convert_flag <= 1'b1;
                end
            end else if (wr_cfg) begin
                cfg <= rx_word[10:0];
                echo_pend <= rx_word[ECHO_BIT];
                echo_word <= rx_word;
            end else if (is_reg) begin
                if (code == REG_UNI) PAIR_UNI <= rx_word[10:0];
                if (code == REG_BIP) PAIR_BIP <= rx_word[10:0];
                if (code == REG_SPAN) SPAN_SEL <= rx_word[10:0];
                if (code == REG_LIST0) list0 <= rx_word[10:0];
                if (code == REG_LIST1) list1 <= rx_word[10:0];
            end
            // sequence load: setup word gives the last index, then 4 entries per word
            if (wr_seq) begin
                seq_last <= rx_word[10:SEQ_LEN_LO];
                load_idx <= 8'h00;
                loading <= 1'b1;
            end else if (word_valid && loading) begin
                load_idx <= load_idx + 8'h04;
                loading <= (9'(load_idx) + 9'h003 < 9'(seq_last));
            end
        end
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            for (int i = 0; i < SEQ_DEPTH; i++) seq_mem[i] <= 4'h0;
        end else if (word_valid && loading) begin
            for (int k = 0; k < 4; k++) seq_mem[load_idx + 8'(k)] <= rx_word[15 - 4 * k -: 4];
        end
    end

    // conversion sequencing
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            state <= ST_IDLE;
            MUX_CH <= CHSEL_RST;
            {CONV_START, EOCN} <= 2'h1;
            acc <= 17'h00000;
            {avg_cnt, rep_cnt} <= 10'h000;
            {ext_res, ext_ch} <= 16'h0000;
            seq_idx <= 8'h00;
        end else begin
            CONV_START <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (frame_start || cnv_fall) EOCN <= 1'b1;
                    if (trig && !first_hit[4]) begin
                        MUX_CH <= first_hit[3:0];
                        {acc, avg_cnt, rep_cnt} <= 27'h0000000;
                        EOCN <= 1'b1;
                        state <= ST_CONV;
                    end else begin
                        if (!int_mode && frame_start) begin
                            CONV_START <= 1'b1;
                            ext_ch <= MUX_CH;
                        end
                        if (!int_mode && CONV_DONE) ext_res <= CONV_DATA;
                        if (is_mode && code == SCAN_MANUAL) begin
                            MUX_CH <= rx_word[10:CHSEL_LO];
                        end else if (mux_step && scan_mode == SCAN_SEQ) begin
                            seq_idx <= seq_next;
                            MUX_CH <= seq_mem[seq_next];
                        end else if (mux_step && ext_auto) begin
                            MUX_CH <= next_hit[4] ? first_hit[3:0] : next_hit[3:0];
                        end
                        if (wr_seq) seq_idx <= 8'h00;
                    end
                end
                ST_CONV: begin
                    CONV_START <= 1'b1;
                    state <= ST_WAIT;
                end
                default: begin
                    if (CONV_DONE && !conv_last) begin
                        acc <= acc_sum;
                        avg_cnt <= avg_cnt + 6'h01;
                        state <= ST_CONV;
                    end else if (CONV_DONE) begin
                        {acc, avg_cnt} <= 23'h000000;
                        if (rep_more) begin
                            rep_cnt <= rep_cnt + 4'h1;
                            state <= ST_CONV;
                        end else if (!next_hit[4]) begin
                            MUX_CH <= next_hit[3:0];
                            state <= ST_CONV;
                        end else begin
                            EOCN <= 1'b0;
                            state <= ST_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // result fifo, overwrite oldest when full
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            for (int i = 0; i < FIFO_DEPTH; i++) fifo_mem[i] <= 16'h0000;
            {wr_ptr, rd_ptr, fifo_cnt} <= 13'h0000;
        end else if (fifo_clr) begin
            for (int i = 0; i < FIFO_DEPTH; i++) fifo_mem[i] <= 16'h0000;
            {wr_ptr, rd_ptr, fifo_cnt} <= 13'h0000;
        end else begin
            if (push) begin
                fifo_mem[wr_ptr] <= {MUX_CH, avg_val};
                wr_ptr <= wr_ptr + 4'h1;
            end
            if (pop || (push && fifo_cnt == 5'h10)) rd_ptr <= rd_ptr + 4'h1;
            if (push && !pop && fifo_cnt != 5'h10) fifo_cnt <= fifo_cnt + 5'h01;
            if (pop && !push) fifo_cnt <= fifo_cnt - 5'h01;
        end
    end

    default clocking @(posedge CLK); endclocking
    default disable iff (!RSTN);

    sw_start_a: assert property (trig && software_convert_flag && !first_hit[4] |=> state == ST_CONV ##1 CONV_START)
        else $error("software convert did not start a scan");
    sw_clear_a: assert property (scan_done && !is_mode |=> !software_convert_flag && !EOCN)
        else $error("software convert flag not cleared at scan end");
    echo_back_a: assert property (wr_cfg && rx_word[ECHO_BIT] |=> echo_pend && echo_word == $past(rx_word))
        else $error("echo word not presented");
    manual_mux_a: assert property (is_mode && code == SCAN_MANUAL && state == ST_IDLE && !trig |=> MUX_CH == $past(rx_word[10:7]))
        else $error("manual channel not applied");
    step_std_a: assert property (state == ST_IDLE && mux_step && scan_mode == SCAN_STD_EXT && !is_mode |=> MUX_CH <= chsel)
        else $error("standard scan stepped outside 0..N");
    fifo_wrap_a: assert property (push && !pop && !fifo_clr && fifo_cnt == 5'h10 |=> fifo_cnt == 5'h10 && rd_ptr == $past(rd_ptr) + 4'h1)
        else $error("full fifo did not drop oldest");
    reset_all_a: assert property (rst_all |=> scan_mode == SCAN_RST && chsel == CHSEL_RST && fifo_cnt == 5'h00)
        else $error("register reset did not restore defaults");
    null_keep_a: assert property (is_mode && new_null && !rst_all |=> $stable(scan_mode) && $stable(chsel))
        else $error("null scan code changed the mode");
    eoc_hold_a: assert property (state != ST_IDLE |-> EOCN)
        else $error("end of conversion low during scan");

    scan_end_c: cover property (scan_done ##[1:300] frame_start);
    fifo_full_c: cover property (push && fifo_cnt == 5'h10);
    seq_load_c: cover property (wr_seq ##[1:1000] !loading);
endmodule : asq_sequencer

// File: shared/asq_pkg.sv
// constants, field layout and types shared by the scan sequencer files
package asq_pkg;
    localparam int WORD_W = 16;
    localparam int CH_W = 4;
    localparam int RES_W = 12;
    localparam int CFG_W = 11;
    localparam int FIFO_DEPTH = 16;
    localparam int PTR_W = 4;
    localparam int SEQ_DEPTH = 256;
    localparam int SEQ_W = 8;
    localparam int ACC_W = 17;
    // serial word fields
    localparam int SEL_BIT = 15;
    localparam int CODE_LO = 11;
    localparam int CHSEL_LO = 7;
    localparam int RSTF_LO = 5;
    localparam int PM_LO = 3;
    localparam int CHANID_BIT = 2;
    localparam int SOFTWARE_CONVERT_FLAG_BIT = 1;
    localparam int SEQ_LEN_LO = 3;
    localparam int LIST_LO = 3;
    // configuration register fields
    localparam int ECHO_BIT = 2;
    localparam int AVG_ON_BIT = 9;
    localparam int NAVG_LO = 7;
    localparam int NSCAN_LO = 5;
    // register select codes
    localparam logic [3:0] REG_CFG = 4'h0;
    localparam logic [3:0] REG_UNI = 4'h1;
    localparam logic [3:0] REG_BIP = 4'h2;
    localparam logic [3:0] REG_SPAN = 4'h3;
    localparam logic [3:0] REG_LIST0 = 4'h4;
    localparam logic [3:0] REG_LIST1 = 4'h5;
    localparam logic [3:0] REG_SEQ = 4'h6;
    // scan mode codes
    localparam logic [3:0] SCAN_NULL = 4'h0;
    localparam logic [3:0] SCAN_MANUAL = 4'h1;
    localparam logic [3:0] SCAN_REPEAT = 4'h2;
    localparam logic [3:0] SCAN_STD_INT = 4'h3;
    localparam logic [3:0] SCAN_STD_EXT = 4'h4;
    localparam logic [3:0] SCAN_UP_INT = 4'h5;
    localparam logic [3:0] SCAN_UP_EXT = 4'h6;
    localparam logic [3:0] SCAN_LIST_INT = 4'h7;
    localparam logic [3:0] SCAN_LIST_EXT = 4'h8;
    localparam logic [3:0] SCAN_SEQ = 4'h9;
    // reset values and reset field codes
    localparam logic [3:0] SCAN_RST = 4'h1;
    localparam logic [3:0] CHSEL_RST = 4'h0;
    localparam logic [1:0] PM_RST = 2'h0;
    localparam logic [10:0] CFG_RST = 11'h000;
    localparam logic [1:0] RSTF_FIFO = 2'h1;
    localparam logic [1:0] RSTF_ALL = 2'h2;
    localparam logic [3:0] CH_TOP = 4'hF;
    // serial clock edge counts within a frame (zero based)
    localparam logic [4:0] RX_LAST_EDGE = 5'h0F;
    localparam logic [4:0] MUX_EDGE = 5'h0C;
    localparam logic [4:0] EDGE_SAT = 5'h1F;
    typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_WAIT} asq_state_t;
endpackage : asq_pkg

// File: src/asq_frame.sv
// serial frame engine: pin synchronisers, 16-bit shift in, shift out, edge events
`timescale 1ns/1ps
module asq_frame (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // pins
    input wire logic sclk,
    input wire logic csn,
    input wire logic din,
    output logic dout,
    // word towards the host, taken at frame start
    input wire logic [asq_pkg::WORD_W-1:0] tx_word,
    // events and received word
    output logic frame_start,
    output logic frame_end,
    output logic word_valid,
    output logic [asq_pkg::WORD_W-1:0] rx_word,
    output logic mux_step,
    output logic cs_idle
);
    import asq_pkg::*;

    logic sclk_s1, sclk_s2, sclk_d;
    logic csn_s1, csn_s2, csn_d;
    logic din_s1, din_s2;
    logic [4:0] rise_cnt, fall_cnt;
    logic [WORD_W-1:0] rx_shift, tx_shift;

    wire sclk_rise = sclk_s2 & ~sclk_d;
    wire sclk_fall = ~sclk_s2 & sclk_d;
    wire cs_fall = ~csn_s2 & csn_d;
    wire cs_rise = csn_s2 & ~csn_d;
    wire in_frame = ~csn_s2 & ~cs_fall;
    wire [WORD_W-1:0] next_rx = {rx_shift[WORD_W-2:0], din_s2};

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {sclk_s1, sclk_s2, sclk_d} <= 3'h7;
            {csn_s1, csn_s2, csn_d} <= 3'h7;
            {din_s1, din_s2} <= 2'h0;
        end else begin
            {sclk_s1, sclk_s2, sclk_d} <= {sclk, sclk_s1, sclk_s2};
            {csn_s1, csn_s2, csn_d} <= {csn, csn_s1, csn_s2};
            {din_s1, din_s2} <= {din, din_s1};
        end
    end

    // input side: data taken on rising serial clock edges
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rise_cnt <= 5'h00;
            rx_shift <= 16'h0000;
            rx_word <= 16'h0000;
            word_valid <= 1'b0;
        end else begin
            word_valid <= 1'b0;
            if (cs_fall) begin
                rise_cnt <= 5'h00;
            end else if (in_frame && sclk_rise && rise_cnt != EDGE_SAT) begin
                rise_cnt <= rise_cnt + 5'h01;
                if (rise_cnt <= RX_LAST_EDGE) begin
                    rx_shift <= next_rx;
                end
                if (rise_cnt == RX_LAST_EDGE) begin
                    rx_word <= next_rx;
                    word_valid <= 1'b1;
                end
            end
        end
    end

    // output side: msb shown from frame start, next bit on each falling edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fall_cnt <= 5'h00;
            tx_shift <= 16'h0000;
            dout <= 1'b0;
            mux_step <= 1'b0;
        end else begin
            mux_step <= 1'b0;
            if (cs_fall) begin
                fall_cnt <= 5'h00;
                tx_shift <= tx_word;
                dout <= tx_word[WORD_W-1];
            end else if (in_frame && sclk_fall && fall_cnt != EDGE_SAT) begin
                fall_cnt <= fall_cnt + 5'h01;
                tx_shift <= {tx_shift[WORD_W-2:0], 1'b0};
                dout <= tx_shift[WORD_W-2];
                mux_step <= (fall_cnt == MUX_EDGE);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            frame_start <= 1'b0;
            frame_end <= 1'b0;
            cs_idle <= 1'b1;
        end else begin
            frame_start <= cs_fall;
            frame_end <= cs_rise;
            cs_idle <= csn_s2 & csn_d;
        end
    end
endmodule : asq_frame

// File: verification/asq_host_model.sv
// serial host model: drives frames on the link pins and collects the answer
`timescale 1ns/1ps
module asq_host_model (
    // clock
    input wire logic clk,
    // link pins
    output logic sclk,
    output logic csn,
    output logic din,
    input wire logic dout
);
    initial begin
        sclk = 1'b1;
        csn = 1'b1;
        din = 1'b1;
    end
    // one frame of n link clocks, msb first; link clock idles high
    task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] rx);
        csn <= 1'b0;
        repeat (4) @(posedge clk);
        for (int i = 0; i < n; i++) begin
            if (i < 16) rx[15-i] = dout;
            sclk <= 1'b0;
            din <= (i < 16) ? w[15-i] : ~din;
            repeat (4) @(posedge clk);
            sclk <= 1'b1;
            repeat (4) @(posedge clk);
        end
        csn <= 1'b1;
        // released data line shows the inverse of its last bit
        din <= ~din;
        repeat (8) @(posedge clk);
    endtask : xfer
endmodule : asq_host_model

// File: verification/test_asq_sequencer.sv
// self-checking bench for the scan sequencer
`timescale 1ns/1ps
`define CHK(a, b, m) begin n_checks++; if ((a) !== (b)) begin n_errors++; \
    $display("BAD %0t %s", $time, m); end end
module test_asq_sequencer;
    import asq_pkg::*;
    logic CLK = 1'b0;
    logic RSTN = 1'b0;
    logic CNVSTN = 1'b1;
    logic CONV_DONE = 1'b0;
    logic [11:0] CONV_DATA = 12'h000;
    wire SCLK, CSN, DIN, DOUT, EOCN, CONV_START;
    wire [3:0] MUX_CH;
    wire [10:0] PAIR_UNI, PAIR_BIP, SPAN_SEL;
    wire [1:0] POWER_MODE;
    logic [15:0] rx;
    logic [3:0] chs[$];
    int n_errors = 0;
    int n_checks = 0;
    always #50 CLK = ~CLK;
    asq_sequencer i_asq_sequencer (.CLK(CLK), .RSTN(RSTN), .SCLK(SCLK), .CSN(CSN),
        .DIN(DIN), .DOUT(DOUT), .CNVSTN(CNVSTN), .EOCN(EOCN), .MUX_CH(MUX_CH),
        .CONV_START(CONV_START), .CONV_DONE(CONV_DONE), .CONV_DATA(CONV_DATA),
        .PAIR_UNI(PAIR_UNI), .PAIR_BIP(PAIR_BIP), .SPAN_SEL(SPAN_SEL),
        .POWER_MODE(POWER_MODE));
    asq_host_model i_asq_host_model (.clk(CLK), .sclk(SCLK), .csn(CSN), .din(DIN),
        .dout(DOUT));
    // converter core: answers one cycle after each start, result tagged with channel
    always @(posedge CLK) begin
        CONV_DONE <= CONV_START;
        CONV_DATA <= {8'hA5, MUX_CH};
        if (CONV_START === 1'b1) chs.push_back(MUX_CH);
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : summarize
    task automatic frame(input logic [15:0] w, input int n);
        i_asq_host_model.xfer(w, n, rx);
    endtask : frame
    task automatic t_reset();
        `CHK(EOCN, 1'b1, "eoc idle")
        `CHK({MUX_CH, POWER_MODE, PAIR_UNI}, 17'h0, "reset outputs")
        $display("test reset done");
    endtask : t_reset
    task automatic t_regs();
        frame({1'b1, REG_UNI, 11'h5A3}, 16);
        frame({1'b1, REG_BIP, 11'h2C7}, 16);
        frame({1'b1, REG_SPAN, 11'h13E}, 16);
        frame({1'b1, 4'hF, 11'h7FF}, 16);
        `CHK({PAIR_UNI, PAIR_BIP, SPAN_SEL}, {11'h5A3, 11'h2C7, 11'h13E}, "reg")
        frame(16'h0010, 16);
        `CHK(POWER_MODE, 2'h2, "null mode pm")
        $display("test regs done");
    endtask : t_regs
    task automatic t_echo();
        frame({1'b1, REG_CFG, 11'h004}, 16);
        frame(16'h0000, 16);
        `CHK(rx, {1'b1, REG_CFG, 11'h004}, "echo word")
        $display("test echo done");
    endtask : t_echo
    task automatic wait_eoc();
        int k;
        k = 0;
        while (EOCN !== 1'b0 && k < 1000) begin
            @(posedge CLK);
            k++;
        end
        `CHK(k < 1000, 1'b1, "no end of scan")
        if (k == 1000) summarize();
    endtask : wait_eoc
    task automatic t_swconv();
        // mode set first so the manual-mode start of this frame is not counted
        frame({1'b0, SCAN_STD_INT, 4'h2, 7'h00}, 16);
        chs.delete();
        frame({1'b0, SCAN_STD_INT, 4'h2, 7'h02}, 17);
        wait_eoc();
        `CHK(chs.size(), 3, "scan count")
        if (chs.size() == 3) `CHK({chs[0], chs[1], chs[2]}, 12'h012, "scan order")
        frame(16'h0020, 16);
        `CHK(rx, 16'h0A50, "fifo head")
        chs.delete();
        frame({1'b1, REG_UNI, 11'h000}, 17);
        repeat (40) @(posedge CLK);
        `CHK(chs.size(), 0, "flag not cleared")
        `CHK(rx, 16'h0000, "fifo not cleared")
        $display("test software convert done");
    endtask : t_swconv
    task automatic t_rst_all();
        frame({1'b1, REG_SPAN, 11'h155}, 16);
        frame(16'h0040, 16);
        `CHK({PAIR_BIP, SPAN_SEL, POWER_MODE}, 24'h0, "reset all")
        $display("test reset all done");
    endtask : t_rst_all
    task automatic t_repeat();
        frame({1'b1, REG_CFG, 11'h380}, 16);
        frame({1'b0, SCAN_REPEAT, 4'h5, 7'h00}, 16);
        chs.delete();
        CNVSTN <= 1'b0;
        repeat (3) @(posedge CLK);
        CNVSTN <= 1'b1;
        wait_eoc();
        `CHK(chs.size(), 128, "repeat count")
        for (int i = 0; i < 4; i++) begin
            frame(16'h0000, 16);
            `CHK(rx, 16'h5A55, "average")
        end
        frame(16'h0000, 16);
        `CHK(rx, 16'h0000, "fifo extra")
        $display("test repeat done");
    endtask : t_repeat
    task automatic t_ext();
        frame({1'b0, SCAN_STD_EXT, 4'h1, 7'h04}, 16);
        repeat (2) frame(16'h0000, 16);
        frame(16'h0000, 16);
        `CHK(rx, 16'h0A50, "ext ch0")
        frame(16'h0000, 16);
        `CHK(rx, 16'h1A51, "ext ch1")
        frame({1'b0, SCAN_MANUAL, 4'h7, 7'h04}, 16);
        repeat (2) frame(16'h0000, 16);
        `CHK(rx, 16'h7A57, "manual result")
        $display("test external done");
    endtask : t_ext
    initial begin
        repeat (6) @(posedge CLK);
        RSTN <= 1'b1;
        repeat (6) @(posedge CLK);
        t_reset();
        t_regs();
        t_echo();
        t_swconv();
        t_rst_all();
        t_repeat();
        t_ext();
        summarize();
    end
endmodule : test_asq_sequencer
